// ---- common/hss_pkg.sv ----
package hss_pkg;
    // serial command layout, msb first
    localparam int CMD_W    = 8;
    localparam int WD_BIT   = 7;
    localparam int ADDR_HI  = 6;
    localparam int ADDR_LO  = 4;
    localparam int DATA_HI  = 3;
    localparam int WATCHDOG_EXPIRED_FLAG_BIT = 2;

    // command addresses
    localparam logic [2:0] A_OUT = 3'h0;
    localparam logic [2:0] A_DIN = 3'h1;
    localparam logic [2:0] A_SNS = 3'h2;
    localparam logic [2:0] A_OC  = 3'h3;
    localparam logic [2:0] A_WDR = 3'h4;

    // values after reset
    localparam logic [1:0] OUT_RST = 2'h0;
    localparam logic [1:0] DIN_RST = 2'h0;
    localparam logic [3:0] OC_DEF  = 4'h0;
    localparam logic [1:0] WDR_DEF = 2'h0;

    // fail-safe resistor code
    localparam logic [1:0] FSI_GND = 2'h0;
    localparam logic [1:0] FSI_OFF = 2'h1;
    localparam logic [1:0] FSI_HS0 = 2'h2;
    localparam logic [1:0] FSI_ON  = 2'h3;

    // watchdog periods in ms, clock in kHz
    localparam int unsigned CLK_KHZ  = 100000;
    localparam int unsigned WDTO0_MS = 620;
    localparam int unsigned WDTO1_MS = 310;
    localparam int unsigned WDTO2_MS = 2500;
    localparam int unsigned WDTO3_MS = 1250;

    typedef enum logic [1:0] {
        HSS_SLEEP    = 2'b00,
        HSS_NORMAL   = 2'b01,
        HSS_FAULT    = 2'b10,
        HSS_FAILSAFE = 2'b11
    } hss_mode_e;
endpackage

// ---- logic/hss_ctrl.sv ----
`timescale 1ns/1ps
// Function
// RL1: serial output driven only while chip select low, else high impedance
// RL2: commands are 8-bit words shifted in msb first
// RL3: serial input captured on each rising shift clock edge
// RL4: host sets each bit up by the preceding falling edge
// RL5: serial output changes right after each rising edge
// RL6: shift clock and data ignored while chip select high
// RL7: host toggles clock once per bit, idle between transfers
// RL8: serial output forwards received bits for daisy chaining
// RL9: reset pin low clears config and faults; with wake low, sleep
// RL10: reset pin rising edge starts the watchdog
// RL11: wake high enables the watchdog function
// RL12: fail-safe select grounded disables watchdog and fail-safe
// RL13: after timeout outputs follow fail-safe select code
// RL14: fault pin pulled low while any fault present
// RL15: direct inputs drive outputs, enabled per output by command
// RL16: loss of logic supply resets all configuration
// RL17: wake and reset pin both low means sleep, outputs off
// RL18: normal mode with reset high, no fault, no timeout
// RL19: fault mode turns only the faulted outputs off
// RL20: fail-safe left only via sleep or grounded select
// RL21: watchdog timeout enters fail-safe, direct inputs still act
// RL22: supplies present brings the device to normal mode
// RL23: host toggles command bit 7 before watchdog expiry
// RL24: status bit 2 reads one while in fail-safe
// RL25: entering fail-safe returns overcurrent settings to default
// RL26: latched faults shifted out on first valid transfer, then cleared
// RL27: command acts at chip select rise, only for whole words
// RL28: command selects sensed output and sense pin tri-state
module hss_ctrl #(
    parameter int unsigned WDTO0_CYC = hss_pkg::WDTO0_MS * hss_pkg::CLK_KHZ,
    parameter int unsigned WDTO1_CYC = hss_pkg::WDTO1_MS * hss_pkg::CLK_KHZ,
    parameter int unsigned WDTO2_CYC = hss_pkg::WDTO2_MS * hss_pkg::CLK_KHZ,
    parameter int unsigned WDTO3_CYC = hss_pkg::WDTO3_MS * hss_pkg::CLK_KHZ
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_si_i,
    output logic            spi_so_o,
    output logic            spi_so_oe_o,
    input  wire logic       reset_pin_n_i,
    input  wire logic       wake_i,
    input  wire logic [1:0] failsafe_select_pin_i,
    input  wire logic [1:0] direct_drive_inputs_i,
    input  wire logic [1:0] fault_det_i,
    input  wire logic       vdd_ok_i,
    output logic [1:0]      power_outputs_o,
    output logic            fault_status_n_o,
    output logic            fault_status_n_oe_o,
    output logic            current_sense_sel_o,
    output logic            current_sense_oe_o,
    output logic [3:0]      oc_cfg_o,
    output logic [1:0]      mode_o
);
    if (WDTO0_CYC < 2 || WDTO1_CYC < 2 || WDTO2_CYC < 2 || WDTO3_CYC < 2)
    begin : g_chk
        $error("watchdog periods must be at least two cycles");
    end

    function automatic logic [31:0] wd_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    wd_limit = WDTO0_CYC - 32'h1;
            2'h1:    wd_limit = WDTO1_CYC - 32'h1;
            2'h2:    wd_limit = WDTO2_CYC - 32'h1;
            default: wd_limit = WDTO3_CYC - 32'h1;
        endcase
    endfunction

    function automatic logic [1:0] fs_pattern(input logic [1:0] code);
        case (code)
            hss_pkg::FSI_ON:  fs_pattern = 2'h3;
            hss_pkg::FSI_HS0: fs_pattern = 2'h1;
            default:          fs_pattern = 2'h0;
        endcase
    endfunction

    // ---- shift clock domain
    logic       start_r;
    logic [2:0] bit_cnt_r;
    logic       full_r;
    logic [7:0] sh_r;
    logic       so_r;
    logic [7:0] tx_word_r;
    logic [2:0] cnt_nxt;
    logic       full_nxt;

    // frame start flag, armed while deselected
    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            start_r <= 1'b1;
        end else begin
            start_r <= 1'b0;
        end
    end

    assign cnt_nxt  = start_r ? 3'h1 : bit_cnt_r + 3'h1;
    assign full_nxt = start_r ? 1'b0 : (full_r | (bit_cnt_r == 3'h7));

    // capture on rising edge, msb first; deselected edges ignored
    always_ff @(posedge spi_sclk_i) begin
        if (!spi_cs_n_i) begin
            sh_r <= {sh_r[6:0], spi_si_i}; // [RL2] [RL3] [RL4] [RL6]
        end
    end

    // count survives chip select rise so the word can be judged
    always_ff @(posedge spi_sclk_i) begin
        if (!spi_cs_n_i) begin
            bit_cnt_r <= cnt_nxt; // [RL6]
            full_r    <= full_nxt;
        end
    end

    // status first, then forward received bits down the chain
    always_ff @(posedge spi_sclk_i) begin
        if (!spi_cs_n_i) begin
            if (full_nxt) begin
                so_r <= sh_r[6]; // [RL8]
            end else begin
                so_r <= tx_word_r[3'h7 - cnt_nxt]; // [RL5]
            end
        end
    end

    // tx word is frozen while selected, so the msb is stable
    assign spi_so_o    = start_r ? tx_word_r[7] : so_r;
    assign spi_so_oe_o = ~spi_cs_n_i; // [RL1]

    // ---- system domain: pin synchronisers
    localparam int SYN_W = 10;
    logic [SYN_W-1:0] syn0_r;
    logic [SYN_W-1:0] syn1_r;
    logic [2:0]       edge_q_r;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            syn0_r <= 10'h200;
            syn1_r <= 10'h200;
        end else begin
            syn0_r <= {spi_cs_n_i, reset_pin_n_i, wake_i,
                       failsafe_select_pin_i, direct_drive_inputs_i,
                       fault_det_i, vdd_ok_i};
            syn1_r <= syn0_r;
        end
    end

    logic       cs_s;
    logic       rst_s;
    logic       wake_s;
    logic [1:0] fsi_s;
    logic [1:0] din_s;
    logic [1:0] flt_s;
    logic       vdd_s;
    logic       any_flt;
    assign cs_s    = syn1_r[9];
    assign rst_s   = syn1_r[8];
    assign wake_s  = syn1_r[7];
    assign fsi_s   = syn1_r[6:5];
    assign din_s   = syn1_r[4:3];
    assign flt_s   = syn1_r[2:1];
    assign vdd_s   = syn1_r[0];
    assign any_flt = |flt_s;

    // previous cs, reset pin, wake for edge detection
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            edge_q_r <= 3'h4;
        end else begin
            edge_q_r <= {cs_s, rst_s, wake_s};
        end
    end

    logic       cs_rise;
    logic       rst_rise;
    logic       wake_rise;
    logic       cmd_take;
    logic       cfg_clr;
    logic       sleep_c;
    logic       fsi_gnd;
    logic [2:0] cmd_addr;
    logic [3:0] cmd_data;
    assign cs_rise   = cs_s & ~edge_q_r[2];
    assign rst_rise  = rst_s & ~edge_q_r[1];
    assign wake_rise = wake_s & ~edge_q_r[0];
    // shift clock is idle once cs has risen, so the word is static here
    assign cmd_take  = cs_rise & full_r & (bit_cnt_r == 3'h0)
                     & rst_s & vdd_s; // [RL27] [RL7]
    assign cfg_clr   = ~rst_s | ~vdd_s; // [RL9] [RL16]
    assign sleep_c   = ~rst_s & ~wake_s;
    assign fsi_gnd   = fsi_s == hss_pkg::FSI_GND;
    assign cmd_addr  = sh_r[hss_pkg::ADDR_HI:hss_pkg::ADDR_LO];
    assign cmd_data  = sh_r[hss_pkg::DATA_HI:0];

    // configuration written by commands
    logic [1:0] out_cmd_r;
    logic [1:0] din_en_r;
    logic       sns_sel_r;
    logic       sns_en_r;
    logic [3:0] oc_cfg_r;
    logic [1:0] wdr_r;
    logic       watchdog_expired_flag_r;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || cfg_clr) begin
            out_cmd_r <= hss_pkg::OUT_RST; // [RL9] [RL16]
            din_en_r  <= hss_pkg::DIN_RST;
            sns_sel_r <= 1'b0;
            sns_en_r  <= 1'b0;
            wdr_r     <= hss_pkg::WDR_DEF;
        end else if (cmd_take) begin
            case (cmd_addr)
                hss_pkg::A_OUT: out_cmd_r <= cmd_data[1:0];
                hss_pkg::A_DIN: din_en_r <= cmd_data[1:0]; // [RL15]
                hss_pkg::A_SNS: begin
                    sns_sel_r <= cmd_data[0]; // [RL28]
                    sns_en_r  <= cmd_data[1];
                end
                hss_pkg::A_WDR: wdr_r <= cmd_data[1:0];
                default: ;
            endcase
        end
    end

    // overcurrent settings fall back to default in fail-safe
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || cfg_clr || watchdog_expired_flag_r) begin
            oc_cfg_r <= hss_pkg::OC_DEF; // [RL25]
        end else if (cmd_take && cmd_addr == hss_pkg::A_OC) begin
            oc_cfg_r <= cmd_data;
        end
    end

    // ---- watchdog
    logic        wd_bit_r;
    logic        wd_run_r;
    logic [31:0] wd_cnt_r;
    logic        wd_kick;
    logic        wd_stop;
    logic        wd_exp;
    assign wd_kick = cmd_take & (sh_r[hss_pkg::WD_BIT] != wd_bit_r); // [RL23]
    assign wd_stop = fsi_gnd | sleep_c | ~vdd_s; // [RL12]
    assign wd_exp  = wd_run_r & ~wd_kick & (wd_cnt_r >= wd_limit(wdr_r));

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || cfg_clr) begin
            wd_bit_r <= 1'b0;
        end else if (cmd_take) begin
            wd_bit_r <= sh_r[hss_pkg::WD_BIT];
        end
    end

    // started by reset pin or wake rising, only if select not grounded
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || wd_stop) begin
            wd_run_r <= 1'b0; // [RL12]
        end else if (rst_rise || wake_rise) begin
            wd_run_r <= 1'b1; // [RL10] [RL11]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !wd_run_r || wd_kick || watchdog_expired_flag_r) begin
            wd_cnt_r <= 32'h0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 32'h1;
        end
    end

    // latched until sleep or select grounded; exit wins over expiry
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || fsi_gnd || sleep_c) begin
            watchdog_expired_flag_r <= 1'b0; // [RL20] [RL12]
        end else if (wd_exp) begin
            watchdog_expired_flag_r <= 1'b1; // [RL23]
        end
    end

    // ---- mode
    hss_pkg::hss_mode_e mode_r;
    hss_pkg::hss_mode_e mode_nxt;

    always_comb begin
        if (sleep_c) begin
            mode_nxt = hss_pkg::HSS_SLEEP; // [RL17] [RL9]
        end else if (watchdog_expired_flag_r) begin
            mode_nxt = hss_pkg::HSS_FAILSAFE; // [RL21]
        end else if (any_flt) begin
            mode_nxt = hss_pkg::HSS_FAULT; // [RL19]
        end else begin
            mode_nxt = hss_pkg::HSS_NORMAL; // [RL18] [RL22]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mode_r <= hss_pkg::HSS_SLEEP;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ---- power outputs
    logic [1:0] drive;
    assign drive = vdd_s ? (out_cmd_r | (din_en_r & din_s))
                         : din_s; // [RL15]

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            power_outputs_o <= 2'h0;
        end else begin
            case (mode_r)
                hss_pkg::HSS_SLEEP: power_outputs_o <= 2'h0; // [RL17]
                hss_pkg::HSS_FAILSAFE:
                    power_outputs_o <= fs_pattern(fsi_s) | din_s; // [RL13] [RL21]
                default: power_outputs_o <= drive & ~flt_s; // [RL19]
            endcase
        end
    end

    // open-drain fault pin pulls low while any fault present
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            fault_status_n_oe_o <= 1'b0;
        end else begin
            fault_status_n_oe_o <= any_flt; // [RL14]
        end
    end
    assign fault_status_n_o = 1'b0;

    // latched faults; a new fault wins over the read clear
    logic [1:0] fault_lat_r;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || cfg_clr) begin
            fault_lat_r <= 2'h0; // [RL9]
        end else if (cmd_take) begin
            fault_lat_r <= flt_s; // [RL26]
        end else begin
            fault_lat_r <= fault_lat_r | flt_s;
        end
    end

    // status word refreshed only while deselected
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tx_word_r <= 8'h00;
        end else if (cs_s) begin
            tx_word_r <= {4'h0, fsi_gnd, watchdog_expired_flag_r, fault_lat_r}; // [RL24] [RL26]
        end
    end

    assign current_sense_sel_o = sns_sel_r; // [RL28]
    assign current_sense_oe_o  = sns_en_r;
    assign oc_cfg_o            = oc_cfg_r;
    assign mode_o              = mode_r;

    // ---- checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    AST_SLEEP_OFF: assert property ( // [RL17]
        mode_r == hss_pkg::HSS_SLEEP |=> power_outputs_o == 2'h0)
        else $error("outputs on in sleep");
    AST_SLEEP_ENTRY: assert property ( // [RL9]
        sleep_c |=> mode_r == hss_pkg::HSS_SLEEP ##1 out_cmd_r == 2'h0)
        else $error("sleep not entered");
    AST_FS_PATTERN: assert property ( // [RL13]
        (mode_r == hss_pkg::HSS_FAILSAFE && din_s == 2'h0 && fsi_s == $past(fsi_s))
        |=> power_outputs_o == fs_pattern($past(fsi_s)))
        else $error("fail-safe output pattern wrong");
    AST_FAULT_PIN: assert property ( // [RL14]
        ##1 fault_status_n_oe_o == $past(any_flt))
        else $error("fault pin does not follow faults");
    AST_FAULT_OFF: assert property ( // [RL19]
        mode_r == hss_pkg::HSS_FAULT |=> (power_outputs_o & $past(flt_s)) == 2'h0)
        else $error("faulted output left on");
    AST_WD_EXPIRE: assert property ( // [RL23]
        (wd_exp && !fsi_gnd && !sleep_c) |=> watchdog_expired_flag_r
        ##1 (mode_r == hss_pkg::HSS_FAILSAFE || sleep_c || fsi_gnd))
        else $error("watchdog expiry missed");
    AST_FSI_GND: assert property ( // [RL12]
        fsi_gnd |=> !watchdog_expired_flag_r && !wd_run_r)
        else $error("grounded select did not stop watchdog");
    AST_OC_REVERT: assert property ( // [RL25]
        watchdog_expired_flag_r |=> oc_cfg_r == hss_pkg::OC_DEF)
        else $error("overcurrent setting kept in fail-safe");
    AST_LATCH_CLR: assert property ( // [RL26]
        cmd_take |=> fault_lat_r == $past(flt_s))
        else $error("fault latch not cleared after read");
    AST_WATCHDOG_EXPIRED_FLAG_BIT: assert property ( // [RL24]
        (cs_s && watchdog_expired_flag_r) |=> tx_word_r[hss_pkg::WATCHDOG_EXPIRED_FLAG_BIT])
        else $error("status bit does not show fail-safe");

    COV_FAILSAFE: cover property (
        $rose(watchdog_expired_flag_r) ##[1:3] mode_r == hss_pkg::HSS_FAILSAFE);
    COV_CMD: cover property (cmd_take && cmd_addr == hss_pkg::A_OUT);
    COV_FAULT: cover property (mode_r == hss_pkg::HSS_FAULT);
    COV_EXIT: cover property (watchdog_expired_flag_r ##1 !watchdog_expired_flag_r);
endmodule

// ---- bench/hss_host.sv ----
`timescale 1ns/1ps
// host-side serial master; xfer clocks inside frames, stray clocks while deselected
module hss_host (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    logic oe_seen;

    // bus idles deselected, clock low, data at its pull-down level
    initial begin
        sclk_o  = 1'b0;
        cs_n_o  = 1'b1;
        si_o    = 1'b0;
        oe_seen = 1'b0;
    end

    // one frame of nb bits, msb first; so read where it stands
    task automatic xfer(input int nb, input logic [15:0] tx,
                        output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_o = 1'b0;
        #3;
        oe_seen = so_oe_i;
        for (int i = nb - 1; i >= 0; i--) begin
            si_o  = tx[i];
            rx[i] = so_i;
            #3;
            sclk_o = 1'b1;
            #3;
            sclk_o = 1'b0;
        end
        #3;
        cs_n_o = 1'b1;
        si_o   = 1'b0; // released line falls to the pull-down
    endtask

    // clock pulses while deselected; the device must not see them
    task automatic stray(input int n);
        si_o = 1'b1;
        repeat (n) begin
            #3 sclk_o = 1'b1;
            #3 sclk_o = 1'b0;
        end
        si_o = 1'b0;
    endtask
endmodule

// ---- bench/smart_switch_spi_mode_control_tb.sv ----
`timescale 1ns/1ps
module smart_switch_spi_mode_control_tb;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        sclk;
    logic        cs_n;
    logic        si;
    logic        so;
    logic        so_oe;
    wire         so_line;
    logic        rst_pin_n = 1'b0;
    logic        wake      = 1'b0;
    logic [1:0]  failsafe_select_pin       = hss_pkg::FSI_GND;
    logic [1:0]  din       = 2'h0;
    logic [1:0]  fdet      = 2'h0;
    logic        vdd_ok    = 1'b1;
    logic [1:0]  pwr;
    logic        fs_n;
    logic        fs_oe;
    logic        sns_sel;
    logic        sns_oe;
    logic [3:0]  oc;
    logic [1:0]  mode;
    logic [15:0] rx;
    logic        wd = 1'b0;
    int          errors = 0;
    int          tests_run = 0;

    always #5 clk_sys = ~clk_sys;
    assign so_line = so_oe ? so : 1'bz;

    // short watchdog periods keep the run brief
    hss_ctrl #(.WDTO0_CYC(300), .WDTO1_CYC(150), .WDTO2_CYC(1000),
               .WDTO3_CYC(500)) dut (
        .clk_sys_i(clk_sys), .reset_i(reset), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_so_o(so),
        .spi_so_oe_o(so_oe), .reset_pin_n_i(rst_pin_n), .wake_i(wake),
        .failsafe_select_pin_i(failsafe_select_pin), .direct_drive_inputs_i(din),
        .fault_det_i(fdet), .vdd_ok_i(vdd_ok), .power_outputs_o(pwr),
        .fault_status_n_o(fs_n), .fault_status_n_oe_o(fs_oe),
        .current_sense_sel_o(sns_sel), .current_sense_oe_o(sns_oe),
        .oc_cfg_o(oc), .mode_o(mode));

    hss_host host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
                   .so_i(so_line), .so_oe_i(so_oe));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // a command with the watchdog bit flipped; short frames undo the flip
    task automatic cmd(input logic [2:0] a, input logic [3:0] d,
                       input int nb = 8);
        wd = ~wd;
        host.xfer(nb, {8'h00, wd, a, d}, rx);
        if (nb != 8) wd = ~wd;
        cyc(6);
    endtask

    // bounded wait for fail-safe entry; a miss ends the run
    task automatic wait_fs;
        int n;
        n = 0;
        while (mode !== hss_pkg::HSS_FAILSAFE && n < 1000) begin
            cyc(1);
            n++;
        end
        if (n >= 1000) begin
            errors++;
            end_sim;
        end
        cyc(2); // outputs are registered one cycle behind the mode
    endtask

    task automatic t_power_up;
        chk(mode, hss_pkg::HSS_SLEEP);
        chk(pwr, 2'h0);
        chk(so_oe, 1'b0);
        rst_pin_n = 1'b1;
        cyc(6);
        chk(mode, hss_pkg::HSS_NORMAL);
    endtask

    // stray clocks first, then a whole word that must act alone
    task automatic t_write;
        host.stray(3);
        chk(so_oe, 1'b0);
        cmd(hss_pkg::A_OUT, 4'h3);
        chk(host.oe_seen, 1'b1);
        chk(pwr, 2'h3);
        chk(rx, 16'h0008);
        cmd(hss_pkg::A_OUT, 4'h0, 7);
        chk(pwr, 2'h3);
    endtask

    // 16-bit chain frame: first byte comes back out, last byte acts
    task automatic t_chain;
        wd = ~wd;
        host.xfer(16, {8'h5a, wd, hss_pkg::A_OUT, 4'h1}, rx);
        cyc(6);
        chk(rx, 16'h085a);
        chk(pwr, 2'h1);
    endtask

    task automatic t_direct_sense;
        cmd(hss_pkg::A_OUT, 4'h0);
        cmd(hss_pkg::A_DIN, 4'h2);
        din = 2'h3;
        cyc(6);
        chk(pwr, 2'h2);
        din = 2'h0;
        cmd(hss_pkg::A_DIN, 4'h0);
        cmd(hss_pkg::A_SNS, 4'h3);
        chk({sns_oe, sns_sel}, 2'h3);
        cmd(hss_pkg::A_SNS, 4'h0);
        chk({sns_oe, sns_sel}, 2'h0);
    endtask

    // fault on output 0 only, then the latched bit is read once
    task automatic t_fault;
        cmd(hss_pkg::A_OUT, 4'h3);
        fdet = 2'h1;
        cyc(6);
        chk(fs_oe, 1'b1);
        chk(fs_n, 1'b0);
        chk(mode, hss_pkg::HSS_FAULT);
        chk(pwr, 2'h2);
        fdet = 2'h0;
        cyc(6);
        chk(fs_oe, 1'b0);
        cmd(hss_pkg::A_OUT, 4'h3);
        chk(rx, 16'h0009);
        cmd(hss_pkg::A_OUT, 4'h3);
        chk(rx, 16'h0008);
    endtask

    task automatic t_vdd;
        cmd(hss_pkg::A_OC, 4'h5);
        chk(oc, 4'h5);
        vdd_ok = 1'b0;
        cyc(6);
        chk(oc, 4'h0);
        vdd_ok = 1'b1;
        cyc(6);
    endtask

    // wake starts the watchdog; feeding holds it off, silence expires it
    task automatic t_watchdog;
        cmd(hss_pkg::A_OUT, 4'h0);
        cmd(hss_pkg::A_OC, 4'ha);
        failsafe_select_pin = hss_pkg::FSI_HS0;
        cyc(6);
        wake = 1'b1;
        cyc(200);
        cmd(hss_pkg::A_SNS, 4'h0);
        cyc(200);
        chk(mode, hss_pkg::HSS_NORMAL);
        wait_fs;
        chk(pwr, 2'h1);
        chk(oc, 4'h0);
        cmd(hss_pkg::A_SNS, 4'h0);
        chk(rx, 16'h0004);
        din = 2'h2;
        cyc(6);
        chk(pwr, 2'h3);
        din = 2'h0;
        failsafe_select_pin = hss_pkg::FSI_GND;
        cyc(8);
        chk(mode, hss_pkg::HSS_NORMAL);
    endtask

    // reset-pin rise starts the watchdog; sleep leaves fail-safe
    task automatic t_reset_pin;
        for (int k = 0; k < 2; k++) begin
            failsafe_select_pin = (k == 0) ? hss_pkg::FSI_OFF : hss_pkg::FSI_ON;
            rst_pin_n = 1'b0;
            wake = 1'b0;
            cyc(6);
            chk(mode, hss_pkg::HSS_SLEEP);
            chk(pwr, 2'h0);
            rst_pin_n = 1'b1;
            wait_fs;
            chk(pwr, (k == 0) ? 2'h0 : 2'h3);
        end
        rst_pin_n = 1'b0;
        cyc(6);
        chk(mode, hss_pkg::HSS_SLEEP);
    endtask

    initial begin
        cyc(10);
        reset = 1'b0;
        cyc(4);
        t_power_up;
        t_write;
        t_chain;
        t_direct_sense;
        t_fault;
        t_vdd;
        t_watchdog;
        t_reset_pin;
        end_sim;
    end
endmodule
